// *** design/fdh_host_port.sv ***
// Fixed disk controller host port and drive control interface
// Notes on behaviour
// R1 - Data port reads drive byte, writes forward
// R2 - Status bit 0 shows transfer request ready
// R3 - Status bit 1 shows direction, 1 input
// R4 - Status bit 2 shows command versus data
// R5 - Status bit 3 busy while executing command
// R6 - Status bit 4 shows DMA transfer ready
// R7 - Status bit 5 shows interrupt pending
// R8 - Status address write resets whole controller
// R9 - Config byte gives drive 0, 1 settings
// R10 - Select write when idle sets busy
// R11 - Enable bit 0 gates DMA requests
// R12 - Enable bit 1 gates interrupt requests
// R13 - Three bit binary head address out
// R14 - Each step pulse moves one track
// R15 - Direction low inward, high outward
// R16 - Write gate only while recording data
// R17 - Reduced current with write gate inside
// R18 - Drive usable only when ready and settled
// R19 - No writing while write fault asserted
// R20 - Only one drive select active
// R21 - Inner cylinders precompensated by 12 ns; the code shifts by 2 clocks of 10 ns, so 20 ns
// R22 - Write data outputs float except writing
// R23 - Request clears after each data access
// R24 - Unused status and config bits zero
module fdh_host_port
  import fdh_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       bus_reset,
  input  wire logic [9:0] io_addr,
  input  wire logic       io_rd_n,
  input  wire logic       io_wr_n,
  input  wire logic       dma_ack_n,
  input  wire logic [7:0] host_data_in,
  output logic      [7:0] host_data_out,
  output logic            host_data_oe,
  output logic            dma_request,
  output logic            interrupt_request,
  input  wire logic [1:0] config_drive0,
  input  wire logic [1:0] config_drive1,
  output logic            core_reset,
  output logic      [7:0] core_byte_out,
  output logic            core_byte_valid,
  input  wire logic [7:0] core_byte_in,
  input  wire logic       core_byte_load,
  input  wire logic       core_xfer_ready,
  input  wire logic       core_dir_in,
  input  wire logic       core_phase_cmd,
  input  wire logic       core_dma_mode,
  input  wire logic       core_done,
  input  wire logic       core_irq_set,
  input  wire logic       core_irq_clear,
  output logic            drive_usable,
  input  wire logic       core_drive,
  input  wire logic [2:0] core_head,
  input  wire logic       core_step,
  input  wire logic       core_step_out,
  input  wire logic       core_write_req,
  input  wire logic       core_write_bit,
  input  wire logic       core_early,
  input  wire logic       core_late,
  input  wire logic [9:0] core_cylinder,
  input  wire logic [9:0] precomp_cylinder,
  output logic            head_address_bit0,
  output logic            head_address_bit1,
  output logic            head_address_bit2,
  output logic            head_step_n,
  output logic            head_direction,
  output logic            write_gate_n,
  output logic            reduced_write_current_n,
  output logic            drive_select_first_n,
  output logic            drive_select_second_n,
  input  wire logic       drive_ready_n,
  input  wire logic       seek_complete_n,
  input  wire logic       write_fault_n,
  input  wire logic       cylinder_zero_flag_n,
  input  wire logic       index_n,
  input  wire logic       read_data_pos,
  input  wire logic       read_data_neg,
  output logic            write_data_pos,
  output logic            write_data_neg,
  output logic            write_data_oe
);
  localparam int STEP_HOLD = STEP_CYC;
  localparam logic [7:0] STEP_LOAD = 8'(STEP_CYC);

  // ----------------------------------------------------------------
  // Reset and host access decode
  // ----------------------------------------------------------------
  logic       rst;
  logic       soft_rst_r;
  logic       rd_d_r;
  logic       wr_d_r;
  logic       rd_start;
  logic       rd_end;
  logic       wr_start;
  logic       dma_cyc;
  logic       hit_data;
  logic       data_rd_end;
  logic       rd_data_hit_r;
  logic       data_wr;
  logic       stat_wr;
  logic       sel_wr;
  logic       en_wr;
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic       rd_hit;

  // Soft strobe joins the resets; it clears itself next cycle
  assign rst = !resetn || bus_reset || soft_rst_r;

  always_ff @(posedge clock) begin
    if (!resetn || bus_reset) begin
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
    end else begin
      rd_d_r <= io_rd_n;
      wr_d_r <= io_wr_n;
    end
  end

  // Acting on edges keeps a long strobe to a single effect
  assign rd_start = rd_d_r && !io_rd_n;
  assign rd_end   = !rd_d_r && io_rd_n;
  assign wr_start = wr_d_r && !io_wr_n;
  assign dma_cyc  = !dma_ack_n;
  assign hit_data = dma_cyc || (io_addr == ADDR_DATA);
  // A read counts as done when the strobe is released; the target is
  // kept from the strobe start since the address may be gone by then
  assign data_rd_end = rd_end && rd_data_hit_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_hit_r <= 1'b0;
    end else if (rd_start) begin
      rd_data_hit_r <= hit_data;
    end
  end
  assign data_wr  = wr_start && hit_data;
  assign stat_wr  = wr_start && !dma_cyc && (io_addr == ADDR_STATUS);
  assign sel_wr   = wr_start && !dma_cyc && (io_addr == ADDR_SELECT);
  assign en_wr    = wr_start && !dma_cyc && (io_addr == ADDR_ENABLE);

  // R8 - Status write resets
  always_ff @(posedge clock) begin
    if (!resetn || bus_reset) begin
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= stat_wr;
    end
  end
  assign core_reset = rst;

  // ----------------------------------------------------------------
  // Controller state and status flags
  // ----------------------------------------------------------------
  fdh_state_t state_r;
  fdh_state_t state_nxt;
  logic       req_r;
  logic       dir_r;
  logic       phase_r;
  logic       irq_r;
  logic       dma_mode_r;
  logic [1:0] enable_r;
  logic       busy;

  // R10 - Select only when idle
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      FDH_IDLE: begin
        if (sel_wr) begin
          state_nxt = FDH_BUSY;
        end
      end
      FDH_BUSY: begin
        if (core_done) begin
          state_nxt = FDH_IDLE;
        end
      end
      default: state_nxt = FDH_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= FDH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  // R5 - Busy from state
  assign busy = (state_r == FDH_BUSY);

  // R23 - Request set wins clear
  always_ff @(posedge clock) begin
    if (rst) begin
      req_r <= 1'b0;
    end else if (core_xfer_ready) begin
      req_r <= 1'b1;
    end else if (data_rd_end || data_wr) begin
      req_r <= 1'b0;
    end
  end

  // R3 - Direction and phase
  always_ff @(posedge clock) begin
    if (rst) begin
      dir_r      <= 1'b0;
      phase_r    <= 1'b0;
      dma_mode_r <= 1'b0;
    end else if (core_xfer_ready) begin
      dir_r      <= core_dir_in;
      phase_r    <= core_phase_cmd;
      dma_mode_r <= core_dma_mode;
    end
  end

  // R7 - Interrupt pending, set wins
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else if (core_irq_set) begin
      irq_r <= 1'b1;
    end else if (core_irq_clear) begin
      irq_r <= 1'b0;
    end
  end

  // R11 - Enable byte, upper bits dropped
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_r <= ENABLE_RST;
    end else if (en_wr) begin
      enable_r <= host_data_in[1:0];
    end
  end

  // R2 - Status byte assembly
  always_comb begin
    status               = BYTE_ZERO;
    status[ST_REQ_BIT]   = req_r;
    status[ST_DIR_BIT]   = dir_r;
    // R4 - Phase bit
    status[ST_PHASE_BIT] = phase_r;
    status[ST_BUSY_BIT]  = busy;
    // R6 - DMA ready bit
    status[ST_DMA_BIT]   = req_r && dma_mode_r;
    status[ST_IRQ_BIT]   = irq_r;
  end

  // R11 - DMA gated
  assign dma_request = status[ST_DMA_BIT] && enable_r[EN_DMA_BIT];
  // R12 - Interrupt gated
  assign interrupt_request = irq_r && enable_r[EN_IRQ_BIT];

  // ----------------------------------------------------------------
  // Data path and read mux
  // ----------------------------------------------------------------
  logic [7:0] byte_in_r;
  logic [7:0] byte_out_r;
  logic       byte_valid_r;
  logic [3:0] cfg_r;
  logic [7:0] rd_data_r;

  // R1 - Byte to host
  always_ff @(posedge clock) begin
    if (rst) begin
      byte_in_r <= BYTE_ZERO;
    end else if (core_byte_load) begin
      byte_in_r <= core_byte_in;
    end
  end

  // R1 - Byte toward drives
  always_ff @(posedge clock) begin
    if (rst) begin
      byte_out_r   <= BYTE_ZERO;
      byte_valid_r <= 1'b0;
    end else begin
      byte_valid_r <= data_wr;
      if (data_wr) begin
        byte_out_r <= host_data_in;
      end
    end
  end
  assign core_byte_out   = byte_out_r;
  assign core_byte_valid = byte_valid_r;

  // Jumpers are sampled each cycle; they only change at power-off
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_r <= 4'h0;
    end else begin
      cfg_r <= {config_drive1, config_drive0};
    end
  end

  // R24 - Unused bits zero
  always_comb begin
    rd_mux = BYTE_ZERO;
    rd_hit = 1'b1;
    if (hit_data) begin
      rd_mux = byte_in_r;
    end else if (io_addr == ADDR_STATUS) begin
      rd_mux = status;
    end else if (io_addr == ADDR_CONFIG) begin
      // R9 - Config byte
      rd_mux = {4'h0, cfg_r};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Data is latched at strobe start so it holds through the read
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_r <= BYTE_ZERO;
    end else if (rd_start) begin
      rd_data_r <= rd_mux;
    end
  end
  assign host_data_out = rd_data_r;
  assign host_data_oe  = !io_rd_n && !rd_d_r && rd_hit;

  // ----------------------------------------------------------------
  // Drive control
  // ----------------------------------------------------------------
  logic [2:0] head_r;
  logic       drive_r;
  logic       dir_out_r;
  logic [7:0] step_cnt_r;
  logic       wg_req_r;
  logic       inner;

  // R18 - Ready and seek complete
  assign drive_usable = !drive_ready_n && !seek_complete_n;
  assign inner = (core_cylinder >= precomp_cylinder);

  always_ff @(posedge clock) begin
    if (rst) begin
      head_r  <= 3'h0;
      drive_r <= 1'b0;
    end else begin
      head_r  <= core_head;
      drive_r <= core_drive;
    end
  end
  // R13 - Binary head address
  assign head_address_bit0 = head_r[0];
  assign head_address_bit1 = head_r[1];
  assign head_address_bit2 = head_r[2];
  // R20 - One select only
  assign drive_select_first_n  = drive_r;
  assign drive_select_second_n = !drive_r;

  // R14 - One pulse per track
  always_ff @(posedge clock) begin
    if (rst) begin
      step_cnt_r <= 8'h00;
      dir_out_r  <= 1'b0;
    end else if (step_cnt_r != 8'h00) begin
      step_cnt_r <= step_cnt_r - 8'h01;
    end else if (core_step && drive_usable) begin
      step_cnt_r <= STEP_LOAD;
      // R15 - Low is inward
      dir_out_r  <= core_step_out;
    end
  end
  assign head_step_n    = (step_cnt_r == 8'h00);
  assign head_direction = dir_out_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      wg_req_r <= 1'b0;
    end else begin
      wg_req_r <= core_write_req;
    end
  end
  // R16 - Gate from request
  // R19 - Fault blocks gate live, with no lag
  assign write_gate_n = !(wg_req_r && drive_usable && write_fault_n);
  // R17 - Reduced current inside
  assign reduced_write_current_n = !(!write_gate_n && inner);

  // ----------------------------------------------------------------
  // Write precompensation
  // ----------------------------------------------------------------
  logic [WD_TAPS-1:0] wd_pipe_r;
  logic [WD_TAPS-1:0] wd_ins;

  // Nominal bits carry one precomp delay so early can lead them
  always_comb begin
    wd_ins = '0;
    if (core_write_bit) begin
      if (inner && core_early) begin
        wd_ins[WD_TAPS-1] = 1'b1;
      end else if (inner && core_late) begin
        wd_ins[0] = 1'b1;
      end else begin
        wd_ins[WD_TAPS-1-PRECOMP_CYC] = 1'b1;
      end
    end
  end

  // R21 - Shift early or late
  always_ff @(posedge clock) begin
    if (rst) begin
      wd_pipe_r <= '0;
    end else begin
      wd_pipe_r <= {wd_pipe_r[WD_TAPS-2:0], 1'b0} | wd_ins;
    end
  end
  assign write_data_pos = wd_pipe_r[WD_TAPS-1];
  assign write_data_neg = !wd_pipe_r[WD_TAPS-1];
  // R22 - Float unless writing
  assign write_data_oe  = !write_gate_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_req_clear;
    @(posedge clock) disable iff (!resetn)
    (data_wr && !core_xfer_ready && !rst) |=> !status[ST_REQ_BIT];
  endproperty
  a_req_clear: assert property (p_req_clear) // R23
    else $error("request flag not cleared after access");

  property p_busy_set;
    @(posedge clock) disable iff (!resetn)
    (sel_wr && !busy && !rst) |=> busy;
  endproperty
  a_busy_set: assert property (p_busy_set) // R10
    else $error("select did not set busy");

  property p_soft_reset;
    @(posedge clock) disable iff (!resetn)
    stat_wr |=> ##1 (status == BYTE_ZERO && enable_r == ENABLE_RST);
  endproperty
  a_soft_reset: assert property (p_soft_reset) // R8
    else $error("status write did not reset controller");

  property p_dma_gate;
    @(posedge clock) disable iff (!resetn)
    dma_request |-> enable_r[EN_DMA_BIT] && req_r && dma_mode_r;
  endproperty
  a_dma_gate: assert property (p_dma_gate) // R11
    else $error("dma request not gated");

  property p_irq_gate;
    @(posedge clock) disable iff (!resetn)
    interrupt_request |-> enable_r[EN_IRQ_BIT] && status[ST_IRQ_BIT];
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R12
    else $error("interrupt not gated");

  property p_wg_safe;
    @(posedge clock) disable iff (!resetn)
    !write_gate_n |-> write_fault_n && !drive_ready_n && !seek_complete_n;
  endproperty
  a_wg_safe: assert property (p_wg_safe) // R19
    else $error("write gate during fault or not ready");

  property p_rwc;
    @(posedge clock) disable iff (!resetn)
    !reduced_write_current_n |-> !write_gate_n && inner;
  endproperty
  a_rwc: assert property (p_rwc) // R17
    else $error("reduced current without write gate");

  property p_wd_float;
    @(posedge clock) disable iff (!resetn)
    write_gate_n |-> !write_data_oe;
  endproperty
  a_wd_float: assert property (p_wd_float) // R22
    else $error("write data driven outside write");

  property p_step_width;
    @(posedge clock) disable iff (!resetn)
    ($fell(head_step_n) && !rst) |-> ##STEP_HOLD $rose(head_step_n);
  endproperty
  a_step_width: assert property (p_step_width) // R14
    else $error("step pulse width wrong");

  property p_dir_hold;
    @(posedge clock) disable iff (!resetn)
    (!head_step_n && !rst) |=> $stable(head_direction) || rst;
  endproperty
  a_dir_hold: assert property (p_dir_hold) // R15
    else $error("direction changed during step");

  property p_one_select;
    @(posedge clock) disable iff (!resetn)
    drive_select_first_n != drive_select_second_n;
  endproperty
  a_one_select: assert property (p_one_select) // R20
    else $error("drive selects not exclusive");

  c_select: cover property (@(posedge clock) sel_wr ##1 busy);
  c_data_wr: cover property (@(posedge clock) data_wr ##1 core_byte_valid);
  c_write: cover property (@(posedge clock) !write_gate_n && inner);
  c_dma: cover property (@(posedge clock) dma_request);
endmodule

// *** design/fdh_pkg.sv ***
// Constants shared by the fixed disk host port logic
package fdh_pkg;
  // ----------------------------------------------------------------
  // Host port addresses
  // ----------------------------------------------------------------
  localparam logic [9:0] ADDR_CONFIG = 10'h302;
  localparam logic [9:0] ADDR_DATA   = 10'h320;
  localparam logic [9:0] ADDR_STATUS = 10'h321;
  localparam logic [9:0] ADDR_SELECT = 10'h322;
  localparam logic [9:0] ADDR_ENABLE = 10'h323;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_REQ_BIT   = 0;
  localparam int ST_DIR_BIT   = 1;
  localparam int ST_PHASE_BIT = 2;
  localparam int ST_BUSY_BIT  = 3;
  localparam int ST_DMA_BIT   = 4;
  localparam int ST_IRQ_BIT   = 5;
  localparam int EN_DMA_BIT   = 0;
  localparam int EN_IRQ_BIT   = 1;
  localparam logic [7:0] BYTE_ZERO  = 8'h00;
  localparam logic [1:0] ENABLE_RST = 2'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRECOMP_NS    = 12;
  localparam int PRECOMP_CYC   =
    (PRECOMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_CYC      =
    (STEP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_TAPS       = 2 * PRECOMP_CYC + 1;
  // ----------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FDH_IDLE = 2'b01,
    FDH_BUSY = 2'b10
  } fdh_state_t;
endpackage

// *** sim/fdh_host_model.sv ***
// Host processor model issuing I/O cycles to the fixed disk port
module fdh_host_model
  import fdh_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] host_data_out,
  input  wire logic       host_data_oe,
  output logic      [9:0] io_addr,
  output logic            io_rd_n,
  output logic            io_wr_n,
  output logic            dma_ack_n,
  output logic      [7:0] host_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial begin
    io_addr = 10'h000;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    dma_ack_n = 1'b1;
    host_data_in = 8'h00;
  end
  // Released address and data lines flip so a stale value is never mistaken for data
  task automatic release_bus();
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
    dma_ack_n = 1'b1;
    host_data_in = ~host_data_in;
    io_addr = ~io_addr;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(negedge clock);
    io_addr = a;
    host_data_in = v;
    io_wr_n = 1'b0;
    @(negedge clock);
    release_bus();
    @(negedge clock);
  endtask
  task automatic rd(input logic [9:0] a, input logic dk,
                    output logic [7:0] v, output logic o);
    @(negedge clock);
    io_addr = a;
    dma_ack_n = ~dk;
    io_rd_n = 1'b0;
    @(negedge clock);
    @(negedge clock);
    v = host_data_out;
    o = host_data_oe;
    release_bus();
    @(negedge clock);
    @(negedge clock);
  endtask
  task automatic wait_req();
    logic [7:0] s;
    logic       o;
    s = 8'h00;
    for (int i = 0; i < 8 && s[ST_REQ_BIT] !== 1'b1; i++) begin
      rd(ADDR_STATUS, 1'b0, s, o);
    end
  endtask
  task automatic sel();
    logic [7:0] s;
    logic       o;
    rd(ADDR_STATUS, 1'b0, s, o);
    if (s[ST_BUSY_BIT] === 1'b0) begin
      wr(ADDR_SELECT, s);
    end
  endtask
endmodule

// *** sim/fdh_host_port_tb.sv ***
// Self-checking bench for the fixed disk host port
module fdh_host_port_tb import fdh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clock, resetn, bus_reset, io_rd_n, io_wr_n, dma_ack_n;
  logic [9:0]  io_addr, core_cylinder, precomp_cylinder;
  logic [7:0]  host_data_in, host_data_out, core_byte_out, core_byte_in;
  logic        host_data_oe, dma_request, interrupt_request, core_reset;
  logic        core_byte_valid, drive_usable, core_dir_in, core_phase_cmd;
  logic [1:0]  config_drive0, config_drive1;
  logic [5:0]  pl;
  logic [2:0]  core_head;
  logic        core_dma_mode, core_drive, core_step_out, core_write_req;
  logic        core_write_bit, core_early, core_late, head_address_bit0;
  logic        head_address_bit1, head_address_bit2, head_step_n;
  logic        head_direction, write_gate_n, reduced_write_current_n;
  logic        drive_select_first_n, drive_select_second_n, drive_ready_n;
  logic        seek_complete_n, write_fault_n, write_data_pos;
  logic        write_data_neg, write_data_oe, oe;
  logic [7:0]  seen, d, x;
  logic [31:0] rs;
  logic [7:0]  q[$];
  int          errors, check_count, n_valid, n_rst, n_low, n0, ne, nl;
  int          m_req, m_dir, m_ph, m_busy, m_dma, m_irq, m_en;
  // ------------------------------------------------------------
  // Instances
  // ------------------------------------------------------------
  fdh_host_port fdh_host_port_i (.clock, .resetn, .bus_reset, .io_addr,
    .io_rd_n, .io_wr_n, .dma_ack_n, .host_data_in, .host_data_out,
    .host_data_oe, .dma_request, .interrupt_request, .config_drive0,
    .config_drive1, .core_reset, .core_byte_out, .core_byte_valid,
    .core_byte_in, .core_byte_load(pl[0]), .core_xfer_ready(pl[1]),
    .core_dir_in, .core_phase_cmd, .core_dma_mode, .core_done(pl[2]),
    .core_irq_set(pl[3]), .core_irq_clear(pl[4]), .drive_usable,
    .core_drive, .core_head, .core_step(pl[5]), .core_step_out,
    .core_write_req, .core_write_bit, .core_early, .core_late,
    .core_cylinder, .precomp_cylinder, .head_address_bit0,
    .head_address_bit1, .head_address_bit2, .head_step_n, .head_direction,
    .write_gate_n, .reduced_write_current_n, .drive_select_first_n,
    .drive_select_second_n, .drive_ready_n, .seek_complete_n,
    .write_fault_n, .cylinder_zero_flag_n(1'b1), .index_n(1'b1),
    .read_data_pos(1'b0), .read_data_neg(1'b1), .write_data_pos,
    .write_data_neg, .write_data_oe);
  fdh_host_model fdh_host_model_i (.clock, .host_data_out, .host_data_oe,
    .io_addr, .io_rd_n, .io_wr_n, .dma_ack_n, .host_data_in);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial clock = 1'b0;
  always #5 clock = ~clock;
  always @(posedge clock) begin
    if (core_byte_valid === 1'b1) begin
      seen <= core_byte_out;
      n_valid <= n_valid + 1;
    end
    if (core_reset === 1'b1) n_rst <= n_rst + 1;
    if (head_step_n === 1'b0) n_low <= n_low + 1;
  end
  function automatic logic [7:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs[7:0];
  endfunction
  function automatic logic [7:0] st();
    return {2'b00, m_irq[0], m_req[0] & m_dma[0], m_busy[0], m_ph[0],
            m_dir[0], m_req[0]};
  endfunction
  task automatic clr();
    {m_req, m_dir, m_ph, m_busy, m_dma, m_irq, m_en} = '0;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cs();
    fdh_host_model_i.rd(ADDR_STATUS, 1'b0, d, oe);
    chk(d, st());
  endtask
  task automatic pulse(input int i);
    @(negedge clock);
    pl[i] = 1'b1;
    @(negedge clock);
    pl[i] = 1'b0;
  endtask
  task automatic lat(input logic e, input logic l, output int n);
    logic p;
    repeat (10) @(negedge clock);
    p = write_data_pos;
    core_early = e;
    core_late = l;
    core_write_bit = 1'b1;
    @(negedge clock);
    core_write_bit = 1'b0;
    n = 1;
    while (write_data_pos === p && n < 20) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    {resetn, bus_reset, pl, core_head, core_drive, core_step_out} = '0;
    {core_dir_in, core_phase_cmd, core_dma_mode, core_write_req} = '0;
    {core_write_bit, core_early, core_late, core_byte_in} = '0;
    {config_drive0, config_drive1, core_cylinder, precomp_cylinder} = '0;
    {drive_ready_n, seek_complete_n, write_fault_n} = 3'b111;
    rs = 32'h0000003F;
    clr();
    repeat (2) @(negedge clock);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      {config_drive1, config_drive0} = x[3:0];
      fdh_host_model_i.rd(ADDR_CONFIG, 1'b0, d, oe);
      chk(d, {4'h0, x[3:0]});
    end
    cs();
    fdh_host_model_i.rd(10'h155, 1'b0, d, oe);
    chk({7'h00, oe}, 8'h00);
    x = rnd();
    fdh_host_model_i.wr(ADDR_ENABLE, {x[7:2], 2'b11});
    m_en = 3;
    fdh_host_model_i.sel();
    m_busy = 1;
    cs();
    for (int k = 0; k < 8; k++) begin
      {core_dma_mode, core_phase_cmd, core_dir_in} = 3'(k);
      pulse(1);
      m_dma = k[2];
      m_ph = k[1];
      m_dir = k[0];
      m_req = 1;
      cs();
      chk({7'h00, dma_request}, {7'h00, k[2]});
    end
    fdh_host_model_i.wait_req();
    x = rnd();
    fdh_host_model_i.wr(ADDR_DATA, x);
    chk(seen, x);
    chk(8'(n_valid), 8'h01);
    m_req = 0;
    cs();
    for (int k = 0; k < 2; k++) begin
      core_byte_in = rnd();
      q.push_back(core_byte_in);
      pulse(0);
      {core_dma_mode, core_phase_cmd, core_dir_in} = {k[0], 2'b01};
      pulse(1);
      m_dma = k;
      m_ph = 0;
      m_dir = 1;
      m_req = 1;
      fdh_host_model_i.wait_req();
      fdh_host_model_i.rd(k ? 10'h000 : ADDR_DATA, k[0], d, oe);
      chk(d, q.pop_front());
      chk({7'h00, oe}, 8'h01);
      m_req = 0;
      cs();
    end
    pulse(3);
    m_irq = 1;
    cs();
    chk({7'h00, interrupt_request}, 8'h01);
    fdh_host_model_i.wr(ADDR_ENABLE, 8'hFC);
    chk({7'h00, interrupt_request}, 8'h00);
    pulse(1);
    chk({7'h00, dma_request}, 8'h00);
    pulse(4);
    pulse(2);
    {m_irq, m_busy, m_req} = {1'b0, 1'b0, 1'b1};
    cs();
    fdh_host_model_i.wr(ADDR_ENABLE, 8'h03);
    pulse(3);
    n_rst = 0;
    fdh_host_model_i.wr(ADDR_STATUS, rnd());
    repeat (3) @(negedge clock);
    chk({7'h00, n_rst > 0}, 8'h01);
    chk({7'h00, interrupt_request}, 8'h00);
    clr();
    cs();
    fdh_host_model_i.sel();
    @(negedge clock);
    bus_reset = 1'b1;
    @(negedge clock);
    bus_reset = 1'b0;
    cs();
    {drive_ready_n, seek_complete_n} = 2'b00;
    for (int k = 0; k < 8; k++) begin
      core_head = 3'(k);
      core_drive = k[0];
      repeat (2) @(negedge clock);
      chk({5'h00, head_address_bit2, head_address_bit1, head_address_bit0},
          8'(k));
      chk({6'h00, drive_select_second_n, drive_select_first_n},
          {6'h00, ~k[0], k[0]});
    end
    chk({7'h00, drive_usable}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      core_step_out = k[0];
      n_low = 0;
      pulse(5);
      repeat (120) @(negedge clock);
      chk(8'(n_low), 8'(STEP_CYC));
      chk({7'h00, head_direction}, 8'(k));
    end
    seek_complete_n = 1'b1;
    n_low = 0;
    pulse(5);
    repeat (5) @(negedge clock);
    chk(8'(n_low), 8'h00);
    chk({7'h00, drive_usable}, 8'h00);
    seek_complete_n = 1'b0;
    precomp_cylinder = 10'h200;
    for (int k = 0; k < 2; k++) begin
      core_cylinder = k ? 10'h200 : 10'h1FF;
      core_write_req = 1'b1;
      repeat (2) @(negedge clock);
      chk({7'h00, write_gate_n}, 8'h00);
      chk({7'h00, write_data_oe}, 8'h01);
      chk({7'h00, reduced_write_current_n}, {7'h00, ~k[0]});
      lat(1'b0, 1'b0, n0);
      lat(1'b1, 1'b0, ne);
      lat(1'b0, 1'b1, nl);
      chk(8'(ne), 8'(k ? n0 - PRECOMP_CYC : n0));
      chk(8'(nl), 8'(k ? n0 + PRECOMP_CYC : n0));
      chk({7'h00, write_data_neg}, {7'h00, ~write_data_pos});
      write_fault_n = 1'b0;
      @(negedge clock);
      chk({7'h00, write_gate_n}, 8'h01);
      write_fault_n = 1'b1;
      core_write_req = 1'b0;
      repeat (2) @(negedge clock);
      chk({7'h00, write_gate_n}, 8'h01);
      chk({7'h00, write_data_oe}, 8'h00);
    end
    conclude();
  end
  initial begin
    #200000;
    errors++;
    conclude();
  end
endmodule
